/* File: bench/cbbx_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module cbbx_checker (
    input wire logic clk,
    input wire logic nrst,
    input wire logic start,
    input wire cbbx_pkg::cbbx_req_t req,
    input wire logic busy,
    input wire logic done,
    input wire logic illegal,
    input wire cbbx_pkg::cbbx_res_t res
);
    import cbbx_pkg::*;
    wire logic go = start && !busy && !done;
    wire logic known = req.opcode inside {OPC_CMP_EQ, OPC_CMP_NE, OPC_BCD_R, OPC_BCD_IR,
        OPC_DEC_R, OPC_DEC_IR};
    wire logic [15:0] tgt = req.pc + {{8{req.offset[7]}}, req.offset};
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence s_go(op, eqv);
        go && req.opcode == op && (req.dst_val == req.src_val) == eqv;
    endsequence
    // done is set by the edge that ends the instruction and is sampled one edge later
    a_eq_taken: assert property (s_go(OPC_CMP_EQ, 1) |-> ##19 done) else $error("cyc");
    a_ne_taken: assert property (s_go(OPC_CMP_NE, 0) |-> ##19 done) else $error("cyc");
    a_ne_stay: assert property (s_go(OPC_CMP_NE, 1) |-> ##17 done) else $error("cyc");
    a_short_done: assert property (go && req.opcode[7:1] inside {7'h00, 7'h20} |->
        ##5 done) else $error("cyc");
    a_ptr_bump: assert property (s_go(OPC_CMP_EQ, 0) |->
        ##17 res.src_ptr == $past(req.src_ptr, 17) + 8'h01) else $error("ptr");
    a_taken_pc: assert property (s_go(OPC_CMP_EQ, 1) |-> ##19 res.pc == $past(tgt, 19))
        else $error("pc");
    a_keep_pc: assert property (s_go(OPC_CMP_NE, 1) |->
        ##17 res.pc == $past(req.pc, 17) && res.flags == $past(req.flags, 17)) else $error("pc");
    a_dec_value: assert property (go && req.opcode == OPC_DEC_R |->
        ##5 res.result == $past(req.dst_val, 5) - 8'h01) else $error("val");
    a_bcd_keep: assert property (go && req.opcode[7:1] == 7'h20 |->
        ##5 res.flags[BIT_D] == $past(req.flags[BIT_D], 5)
        && res.flags[BIT_H] == $past(req.flags[BIT_H], 5)) else $error("flg");
    a_bad_opcode: assert property (go && !known |-> ##1 illegal && !busy) else $error("ill");
endmodule
bind cbbx_exec cbbx_checker chk_u (.clk, .nrst, .start, .req, .busy, .done, .illegal, .res);
`default_nettype wire

/* File: bench/compare_branch_bcd_adjust_exec_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module compare_branch_bcd_adjust_exec_tb;
    import cbbx_pkg::*;
    logic clk = 1'b0, nrst = 1'b0, start = 1'b0, busy, done, illegal;
    cbbx_req_t req = '0;
    cbbx_res_t res;
    int error_cnt = 0, checks_done = 0;
    cbbx_exec dut_u (.clk, .nrst, .start, .req, .busy, .done, .illegal, .res);
    always #4 clk = ~clk;
    task automatic chk(input logic [31:0] got, exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t %h %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("errors %0d checks %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic run(input logic [7:0] op, dst, src, off, fl, input int cyc);
        int n;
        req = '{op, dst, src, 8'h30, off, 16'h0100, fl};
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        for (n = 0; done !== 1'b1 && n < 40; n++) @(negedge clk);
        chk(n, cyc);
        @(negedge clk); // one idle edge between instructions
    endtask
    task automatic t_bad();
        cbbx_res_t keep;
        keep = res;
        req = '{8'h02, 8'h11, 8'h22, 8'h30, 8'h05, 16'h0200, 8'h00};
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        chk({busy, illegal, done}, 3'b010);
        chk({res.pc, res.result, res.flags}, {keep.pc, keep.result, keep.flags});
        @(negedge clk);
        chk({busy, illegal, done}, 3'b000);
    endtask
    task automatic t_cmp();
        run(OPC_CMP_EQ, 8'h02, 8'h02, 8'h80, 8'hF4, 18);
        chk({res.pc, res.src_ptr, res.flags}, 32'h0080_31F4);
        run(OPC_CMP_EQ, 8'h02, 8'h03, 8'h80, 8'h00, 16);
        chk({res.pc, res.src_ptr, res.flags}, 32'h0100_3100);
        run(OPC_CMP_NE, 8'h02, 8'h04, 8'h7F, 8'h0C, 18);
        chk({res.pc, res.src_ptr, res.flags}, 32'h017F_310C);
        run(OPC_CMP_NE, 8'h05, 8'h05, 8'h7F, 8'h00, 16);
        chk({res.pc, res.src_ptr, res.flags}, 32'h0100_3100);
    endtask
    task automatic alu(input logic [7:0] op, dst, fl, r, f); // v is open after bcd
        run(op, dst, 8'h00, 8'h00, fl, 4);
        chk({res.result, res.flags & (op[6] ? 8'hEC : 8'hFC)}, {r, f});
    endtask
    task automatic t_alu();
        alu(OPC_BCD_R, 8'h8A, 8'h00, 8'h90, 8'h20);
        alu(OPC_BCD_IR, 8'hA5, 8'h00, 8'h05, 8'h80);
        alu(OPC_BCD_R, 8'h9A, 8'h00, 8'h00, 8'hC0);
        alu(OPC_BCD_IR, 8'h2F, 8'h0C, 8'h29, 8'h0C);
        alu(OPC_BCD_R, 8'h95, 8'h88, 8'h35, 8'h88);
        alu(OPC_BCD_R, 8'h7B, 8'h8C, 8'h15, 8'h8C);
        alu(OPC_DEC_R, 8'h80, 8'h8C, 8'h7F, 8'h9C);
        alu(OPC_DEC_IR, 8'h01, 8'h00, 8'h00, 8'h40);
    endtask
    initial begin
        repeat (2) @(negedge clk);
        nrst = 1'b1;
        t_cmp();
        t_alu();
        t_bad();
        print_verdict();
    end
    initial begin
        #20000;
        error_cnt++;
        print_verdict();
    end
endmodule
`default_nettype wire

/* File: core/cbbx_exec.sv */
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - equal-compare opcode branches by offset when dst minus src is zero; flags kept
// - unequal-compare opcode branches by offset when difference nonzero; flags kept
// - both compares bump the source pointer register by one, taken or not
// - compares are three bytes; 18 cycles taken, 16 cycles not taken
// - branch offset is signed, reach plus 127 to minus 128 bytes
// - bcd correction turns the byte into two packed bcd digits
// - after add, table picks 00/06/60/66; carry set for 60 and 66
// - after subtract, add 00/FA/A0/9A; carry set only for A0 and 9A
// - bcd correction carry follows the table, cleared otherwise
// - bcd sets zero and sign, keeps decimal and half-carry; 4 cycles
// - decrement writes dst minus one; two bytes, 4 cycles
// - decrement updates zero, sign, overflow; keeps carry, decimal, half-carry
module cbbx_exec #(
    parameter int CNT_W = 5
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic start,
    input wire cbbx_pkg::cbbx_req_t req,
    output logic busy,
    output logic done,
    output logic illegal,
    output cbbx_pkg::cbbx_res_t res
);
    import cbbx_pkg::*;

    // counter loads are one less than the cycle figure: the FIN edge counts as one
    localparam logic [CNT_W-1:0] CNT_TAKEN = CNT_W'(CYC_BR_TAKEN - 1);
    localparam logic [CNT_W-1:0] CNT_NOT = CNT_W'(CYC_BR_NOT - 1);
    localparam logic [CNT_W-1:0] CNT_SHORT = CNT_W'(CYC_SHORT - 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(1);
    localparam logic [7:0] BYTE_ONE = 8'h01;
    localparam logic [7:0] BYTE_MIN_NEG = 8'h80;

    // a narrower counter would wrap before the longest branch completes
    if ((2 ** CNT_W) <= CYC_BR_TAKEN) begin : g_cnt_width
        $error("cbbx_exec: CNT_W cannot hold the longest cycle count");
    end
    // the countdown needs at least two cycles to pass through the run state
    if (CYC_SHORT < 2 || CYC_BR_NOT < 2) begin : g_cnt_floor
        $error("cbbx_exec: cycle counts below two are not supported");
    end

    typedef enum logic [1:0] {IDLE, RUN, FIN} cbbx_state_t;

    cbbx_state_t state_reg, state_next;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    cbbx_res_t res_reg, res_next;
    logic busy_reg, busy_next;
    logic done_reg, done_next;
    logic ill_reg, ill_next;

    logic [7:0] diff;
    logic is_cmp, is_bcd, is_dec, hit;
    logic [7:0] corr, bcd_val, dec_val;
    logic bcd_c;
    logic [3:0] hi, lo;
    logic c_in, h_in, d_in;
    logic [7:0] fl;
    logic [15:0] offset_ext;
    logic legal;

    // operand decode and the bcd table are pure functions of the request
    always_comb begin
        diff = req.dst_val - req.src_val;
        is_cmp = (req.opcode == OPC_CMP_EQ) || (req.opcode == OPC_CMP_NE);
        is_bcd = (req.opcode == OPC_BCD_R) || (req.opcode == OPC_BCD_IR);
        is_dec = (req.opcode == OPC_DEC_R) || (req.opcode == OPC_DEC_IR);
        legal = is_cmp || is_bcd || is_dec;
        hit = (req.opcode == OPC_CMP_EQ) ? (diff == CORR_00) : (diff != CORR_00);
        hi = req.dst_val[7:4];
        lo = req.dst_val[3:0];
        c_in = req.flags[BIT_C];
        h_in = req.flags[BIT_H];
        d_in = req.flags[BIT_D];
        corr = CORR_00;
        bcd_c = 1'b0;
        if (!d_in) begin
            // addition side; cases outside the table are undefined, so ranges are merged
            if (c_in) begin
                corr = (h_in || lo > NIB_9) ? CORR_66 : CORR_60;
                bcd_c = 1'b1;
            end else if (hi > NIB_9 || (hi > NIB_8 && lo > NIB_9)) begin
                corr = (h_in || lo > NIB_9) ? CORR_66 : CORR_60;
                bcd_c = 1'b1;
            end else if (h_in || lo > NIB_9) begin
                corr = CORR_06;
            end
        end else begin
            if (c_in) begin
                corr = h_in ? CORR_9A : CORR_A0;
                bcd_c = 1'b1;
            end else if (h_in) begin
                corr = CORR_FA;
            end
        end
        bcd_val = req.dst_val + corr;
        dec_val = req.dst_val - BYTE_ONE;
        // the offset byte is signed, so the reach is +127 to -128 around the next pc
        offset_ext = {{8{req.offset[7]}}, req.offset};
    end

    // control: sequencing, cycle count and handshake pulses
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        busy_next = busy_reg;
        done_next = 1'b0;
        ill_next = 1'b0;
        case (state_reg)
            IDLE: begin
                // only legal opcodes leave idle; start is looked at elsewhere only by the result block, in idle
                if (start) begin
                    if (is_cmp) begin
                        cnt_next = hit ? CNT_TAKEN : CNT_NOT;
                        state_next = RUN;
                        busy_next = 1'b1;
                    end else if (is_bcd) begin
                        cnt_next = CNT_SHORT;
                        state_next = RUN;
                        busy_next = 1'b1;
                    end else if (is_dec) begin
                        cnt_next = CNT_SHORT;
                        state_next = RUN;
                        busy_next = 1'b1;
                    end else begin
                        // unknown opcodes only flag themselves; nothing is written back
                        ill_next = 1'b1;
                    end
                end
            end
            RUN: begin
                // result is held; the core samples it when done pulses
                if (cnt_reg == CNT_LAST) begin
                    state_next = FIN;
                end
                cnt_next = cnt_reg - CNT_LAST;
            end
            FIN: begin
                // busy falls with done, so the next start may come at the following edge
                done_next = 1'b1;
                busy_next = 1'b0;
                state_next = IDLE;
            end
            default: begin
                state_next = IDLE;
                busy_next = 1'b0;
            end
        endcase
    end

    // result: computed once at acceptance, then held until the next accepted start
    always_comb begin
        res_next = res_reg;
        fl = req.flags;
        if (state_reg == IDLE && start && legal) begin
            res_next.flags = req.flags;
            res_next.result_we = 1'b0;
            res_next.ptr_we = 1'b0;
            res_next.taken = 1'b0;
            res_next.src_ptr = req.src_ptr;
            res_next.result = req.dst_val;
            res_next.pc = req.pc;
            if (is_cmp) begin
                // the pointer bump travels with the result, so it lands before done
                res_next.src_ptr = req.src_ptr + BYTE_ONE;
                res_next.ptr_we = 1'b1;
                res_next.taken = hit;
                res_next.pc = hit ? req.pc + offset_ext : req.pc;
            end else if (is_bcd) begin
                // overflow passes through: its value after the adjust is undefined
                fl[BIT_C] = bcd_c;
                fl[BIT_Z] = (bcd_val == CORR_00);
                fl[BIT_S] = bcd_val[7];
                res_next.flags = fl;
                res_next.result = bcd_val;
                res_next.result_we = 1'b1;
            end else begin
                // carry, decimal and half-carry pass through from the request
                fl[BIT_Z] = (dec_val == CORR_00);
                fl[BIT_S] = dec_val[7];
                fl[BIT_V] = (req.dst_val == BYTE_MIN_NEG);
                res_next.flags = fl;
                res_next.result = dec_val;
                res_next.result_we = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= IDLE;
            cnt_reg <= '0;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
            ill_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            busy_reg <= busy_next;
            done_reg <= done_next;
            ill_reg <= ill_next;
        end
    end

    // the result flops have no enable of their own: the next-value side holds them
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            res_reg <= '0;
        end else begin
            res_reg <= res_next;
        end
    end

    assign busy = busy_reg;
    assign done = done_reg;
    assign illegal = ill_reg;
    assign res = res_reg;
endmodule
`default_nettype wire

/* File: inc/cbbx_pkg.sv */
package cbbx_pkg;
    localparam logic [7:0] OPC_CMP_EQ = 8'hC2;
    localparam logic [7:0] OPC_CMP_NE = 8'hD2;
    localparam logic [7:0] OPC_BCD_R = 8'h40;
    localparam logic [7:0] OPC_BCD_IR = 8'h41;
    localparam logic [7:0] OPC_DEC_R = 8'h00;
    localparam logic [7:0] OPC_DEC_IR = 8'h01;
    localparam int CYC_BR_TAKEN = 18;
    localparam int CYC_BR_NOT = 16;
    localparam int CYC_SHORT = 4;
    localparam logic [7:0] CORR_00 = 8'h00;
    localparam logic [7:0] CORR_06 = 8'h06;
    localparam logic [7:0] CORR_60 = 8'h60;
    localparam logic [7:0] CORR_66 = 8'h66;
    localparam logic [7:0] CORR_FA = 8'hFA;
    localparam logic [7:0] CORR_A0 = 8'hA0;
    localparam logic [7:0] CORR_9A = 8'h9A;
    localparam logic [3:0] NIB_2 = 4'h2;
    localparam logic [3:0] NIB_3 = 4'h3;
    localparam logic [3:0] NIB_5 = 4'h5;
    localparam logic [3:0] NIB_6 = 4'h6;
    localparam logic [3:0] NIB_8 = 4'h8;
    localparam logic [3:0] NIB_9 = 4'h9;
    localparam int BIT_C = 7;
    localparam int BIT_Z = 6;
    localparam int BIT_S = 5;
    localparam int BIT_V = 4;
    localparam int BIT_D = 3;
    localparam int BIT_H = 2;

    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] dst_val;
        logic [7:0] src_val;
        logic [7:0] src_ptr;
        logic [7:0] offset;
        logic [15:0] pc;
        logic [7:0] flags;
    } cbbx_req_t;

    typedef struct packed {
        logic [15:0] pc;
        logic [7:0] result;
        logic result_we;
        logic [7:0] src_ptr;
        logic ptr_we;
        logic [7:0] flags;
        logic taken;
    } cbbx_res_t;
endpackage
